// file: verilog/core_regulator_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module core_regulator_reset_sequencer
    import regulator_seq_pkg::*;
#(
    parameter logic                 POSITIVE_ENABLE = 1'b1,  // strap variant
    parameter logic [REV_ID_W-1:0]  REVISION_ID     = 4'h1,  // arbitrary value
    parameter int unsigned          POWERUP_CYCLES  = POWERUP_CYC,
    parameter int unsigned          CNT_W           = 24
) (
    input  wire logic                                 core_clk,
    input  wire logic                                 sys_rst,
    input  wire logic                                 clk_en,
    input  wire logic                                 regulator_strap,
    input  wire logic                                 supply_stable,
    input  wire logic                                 full_speed_ok,
    input  wire logic                                 tracking_ok,
    input  wire logic                                 regulator_short,
    input  wire logic                                 wake_event,
    input  wire logic [regulator_seq_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [regulator_seq_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                                 reg_wr,
    input  wire logic                                 reg_rd,
    output var  logic [regulator_seq_pkg::DATA_W-1:0] reg_rdata,
    output var  logic                                 exec_enable,
    output var  logic                                 brownout_reset,
    output var  logic                                 tracking_mode,
    output var  logic                                 full_speed_allowed,
    output var  logic                                 low_voltage_flag,
    output var  logic                                 regulator_enabled
);
    import regulator_seq_pkg::*;

    // counter loads, typed at counter width
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] DELAY_LOAD  = CNT_W'(POWERUP_CYCLES - 1);

    // refuse counts the counter cannot hold
    initial begin
        if (POWERUP_CYCLES < 1 || SETTLE_CYCLES < 1)
            $error("sequencer: delay counts must be at least one cycle");
        if (CNT_W > 31 || (64'(1) << CNT_W) <= 64'(POWERUP_CYCLES))
            $error("sequencer: CNT_W too small for power-up count");
        if ((64'(1) << CNT_W) <= 64'(SETTLE_CYCLES))
            $error("sequencer: CNT_W too small for settle count");
    end

    // strap level to regulator decision for the built variant
    function automatic logic strap_means_on(input logic level);
        return POSITIVE_ENABLE ? level : ~level;
    endfunction : strap_means_on

    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    detector_s det_raw;  // pin levels as they arrive
    detector_s det;      // after two flops
    reg_req_s  req;      // register port, same clock, no sync

    assign det_raw.strap_level     = regulator_strap;
    assign det_raw.supply_stable   = supply_stable;
    assign det_raw.full_speed_ok   = full_speed_ok;
    assign det_raw.tracking_ok     = tracking_ok;
    assign det_raw.regulator_short = regulator_short;
    assign det_raw.wake            = wake_event;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    // every analog detector level is retimed before use
    detector_sync #(
        .W        ($bits(detector_s))
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in (det_raw),
        .sync_out (det)
    );

    // ---------------------------------------------------------------
    // state and registers
    // ---------------------------------------------------------------
    seq_state_e        state_r, state_nxt;     // sequencer state
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;         // hold-off down counter
    logic              reg_on_r, reg_on_nxt;   // latched strap decision
    logic              wake_prev_r;            // for wake edge detect
    logic [1:0]        cause_r, cause_nxt;     // reset cause bits
    logic              lv_flag_r, lv_flag_nxt; // sticky low-voltage flag
    logic              det_en_r, det_en_nxt;   // detection enable
    logic [DATA_W-1:0] rdata_nxt;              // read mux result

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire hit_rev    = (req.addr == OFS_SILICON_REVISION);
    wire hit_cause  = (req.addr == OFS_CONTROL) ? 1'b0 : (req.addr == OFS_RESET_CAUSE);
    wire hit_status = (req.addr == OFS_STATUS);
    wire hit_ctrl   = (req.addr == OFS_CONTROL);

    wire wr_cause  = req.wr & hit_cause;
    wire wr_status = req.wr & hit_status;
    wire wr_ctrl   = req.wr & hit_ctrl;

    // sleep is a command bit, it never stores
    wire sleep_cmd = wr_ctrl & req.wdata[CTRL_SLEEP_BIT];

    // ---------------------------------------------------------------
    // supply conditions
    // ---------------------------------------------------------------
    // brownout only exists with the regulator running
    wire bo_short   = reg_on_r & det.regulator_short;
    wire bo_low     = reg_on_r & ~det.tracking_ok;
    wire bo_cond    = bo_short | bo_low;

    // tracking when supply is under the full-speed level
    wire tracking   = reg_on_r & ~det.full_speed_ok;

    // detection gated by regulator state and software enable
    wire lv_detect  = reg_on_r & det_en_r & ~det.full_speed_ok;

    // rising edge of the retimed wake level
    wire wake_rise  = det.wake & ~wake_prev_r;

    // counter expiry
    wire cnt_done   = (cnt_r == '0);

    // strap decision as seen now, used once at power-on exit
    wire strap_on   = strap_means_on(det.strap_level);

    // ---------------------------------------------------------------
    // sequencer next state
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_done ? cnt_r : cnt_r - CNT_W'(1);
        reg_on_nxt = reg_on_r;
        case (state_r)
            ST_POWERON: begin
                // the synchronisers have filled by the time stable is seen
                if (det.supply_stable) begin
                    reg_on_nxt = strap_on;
                    if (strap_on) begin
                        state_nxt = ST_SETTLE;
                        cnt_nxt   = SETTLE_LOAD;
                    end else begin
                        state_nxt = ST_DELAY;
                        cnt_nxt   = DELAY_LOAD;
                    end
                end
            end
            ST_SETTLE: begin
                // execution stays blocked until the count runs out
                if (bo_cond) begin
                    state_nxt = ST_BROWNOUT;
                end else if (cnt_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DELAY: begin
                // regulator off: no brownout path, just wait
                if (cnt_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (bo_cond) begin
                    state_nxt = ST_BROWNOUT;
                end else if (sleep_cmd) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (bo_cond) begin
                    state_nxt = ST_BROWNOUT;
                end else if (wake_rise) begin
                    // regulator on: settle again on every resume
                    if (reg_on_r) begin
                        state_nxt = ST_SETTLE;
                        cnt_nxt   = SETTLE_LOAD;
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_BROWNOUT: begin
                // held in reset until supply is good, then settle anew
                if (!bo_cond && det.supply_stable) begin
                    state_nxt = ST_SETTLE;
                    cnt_nxt   = SETTLE_LOAD;
                end
            end
            default: begin
                // illegal code: restart the sequence cleanly
                state_nxt = ST_POWERON;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // software visible flags
    // ---------------------------------------------------------------
    // cause bits: software clears by writing 0, hardware set wins
    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = cause_r & req.wdata[1:0];
        end
        if (state_nxt == ST_BROWNOUT && state_r != ST_BROWNOUT) begin
            cause_nxt[CAUSE_BROWNOUT_BIT] = 1'b1;
        end
    end

    // low-voltage flag: write 1 clears, a live condition wins
    always_comb begin
        lv_flag_nxt = lv_flag_r;
        if (wr_status && req.wdata[STAT_LV_FLAG_BIT]) begin
            lv_flag_nxt = 1'b0;
        end
        if (lv_detect) begin
            lv_flag_nxt = 1'b1;
        end
    end

    // detection enable bit of the control register
    always_comb begin
        det_en_nxt = det_en_r;
        if (wr_ctrl) begin
            det_en_nxt = req.wdata[CTRL_DET_EN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // read mux, unmapped offsets read zero
    // ---------------------------------------------------------------
    wire [DATA_W-1:0] rev_word = DATA_W'({{(REV_WORD_W-REV_ID_W){1'b0}}, REVISION_ID});

    wire [DATA_W-1:0] status_word = DATA_W'({
        full_speed_allowed,
        exec_enable,
        reg_on_r,
        tracking_mode,
        lv_flag_r
    });

    always_comb begin
        rdata_nxt = '0;
        if (req.rd) begin
            case (1'b1)
                hit_rev:    rdata_nxt = rev_word;
                hit_cause:  rdata_nxt = DATA_W'(cause_r);
                hit_status: rdata_nxt = status_word;
                hit_ctrl:   rdata_nxt = DATA_W'(det_en_r);
                default:    rdata_nxt = '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state flops, everything frozen while clk_en is low
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r     <= ST_POWERON;
            cnt_r       <= '0;
            reg_on_r    <= 1'b0;
            wake_prev_r <= 1'b0;
        end else if (clk_en) begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            reg_on_r    <= reg_on_nxt;
            wake_prev_r <= det.wake;
        end
    end

    // software registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cause_r   <= CAUSE_RESET;
            lv_flag_r <= 1'b0;
            det_en_r  <= DET_EN_RESET;
            reg_rdata <= '0;
        end else if (clk_en) begin
            cause_r   <= cause_nxt;
            lv_flag_r <= lv_flag_nxt;
            det_en_r  <= det_en_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // outputs registered from next-state values, tracking_mode and the full_speed_allowed mask from the present tracking term
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            exec_enable        <= 1'b0;
            brownout_reset     <= 1'b0;
            tracking_mode      <= 1'b0;
            full_speed_allowed <= 1'b0;
            low_voltage_flag   <= 1'b0;
            regulator_enabled  <= 1'b0;
        end else if (clk_en) begin
            exec_enable        <= (state_nxt == ST_RUN);
            brownout_reset     <= (state_nxt == ST_BROWNOUT);
            tracking_mode      <= tracking;
            full_speed_allowed <= (state_nxt == ST_RUN) & ~tracking;
            low_voltage_flag   <= lv_flag_nxt;
            regulator_enabled  <= reg_on_nxt;
        end
    end

endmodule : core_regulator_reset_sequencer
`default_nettype wire

// file: verilog/regulator_seq_pkg.sv
package regulator_seq_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_SILICON_REVISION = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE      = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS           = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CONTROL          = 4'hc;

    // silicon revision word layout
    localparam int unsigned REV_WORD_W = 24;
    localparam int unsigned REV_ID_W   = 4;

    // reset cause register bit positions
    localparam int unsigned CAUSE_POWERUP_BIT  = 0;
    localparam int unsigned CAUSE_BROWNOUT_BIT = 1;

    // status register bit positions
    localparam int unsigned STAT_LV_FLAG_BIT    = 0;
    localparam int unsigned STAT_TRACKING_BIT   = 1;
    localparam int unsigned STAT_REG_ON_BIT     = 2;
    localparam int unsigned STAT_EXEC_BIT       = 3;
    localparam int unsigned STAT_FULL_SPEED_BIT = 4;

    // control register bit positions
    localparam int unsigned CTRL_DET_EN_BIT = 0;
    localparam int unsigned CTRL_SLEEP_BIT  = 1;

    // values after reset
    localparam logic [1:0] CAUSE_RESET   = 2'h1;
    localparam logic       DET_EN_RESET  = 1'b1;

    // timing, figures as specified, and the clock they are counted on
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned SETTLE_TIME_NS = 20000;
    localparam int unsigned POWERUP_MS     = 64;
    // least times, rounded up to whole cycles
    localparam int unsigned SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POWERUP_CYC =
        (POWERUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_POWERON  = 6'h01,
        ST_SETTLE   = 6'h02,
        ST_DELAY    = 6'h04,
        ST_RUN      = 6'h08,
        ST_SLEEP    = 6'h10,
        ST_BROWNOUT = 6'h20
    } seq_state_e;

    // levels from outside the clock domain, travel together
    typedef struct packed {
        logic strap_level;
        logic supply_stable;
        logic full_speed_ok;
        logic tracking_ok;
        logic regulator_short;
        logic wake;
    } detector_s;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

endpackage : regulator_seq_pkg

// file: verilog/detector_sync.sv
`timescale 1ns/1ps
`default_nettype none
module detector_sync
    import regulator_seq_pkg::*;
#(
    parameter int unsigned W = $bits(detector_s)
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    // first stage is read only by the second stage
    logic [W-1:0] meta_r;

    initial begin
        if (W < 1) $error("detector_sync: W must be at least 1");
    end

    // two flops per level, frozen with the clock enable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : detector_sync
`default_nettype wire

// file: bench/regulator_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module regulator_seq_checker
    import regulator_seq_pkg::*;
#(
    parameter logic [regulator_seq_pkg::REV_ID_W-1:0] REVISION_ID = 4'h1
) (
    input wire logic                                 core_clk,
    input wire logic                                 sys_rst,
    input wire logic [regulator_seq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                                 reg_rd,
    input wire logic [regulator_seq_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                                 regulator_short,
    input wire logic                                 full_speed_ok,
    input wire logic                                 exec_enable,
    input wire logic                                 brownout_reset,
    input wire logic                                 tracking_mode,
    input wire logic                                 full_speed_allowed,
    input wire logic                                 low_voltage_flag,
    input wire logic                                 regulator_enabled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] low_cnt_r; // cycles spent with code held off
    // saturating hold-off counter, cleared whenever code runs
    always_ff @(posedge core_clk) begin
        if (sys_rst || exec_enable) begin
            low_cnt_r <= 16'h0;
        end else if (low_cnt_r != 16'hffff) begin
            low_cnt_r <= low_cnt_r + 16'h1;
        end
    end
    sequence s_rev_read;
        reg_rd && (reg_addr == OFS_SILICON_REVISION);
    endsequence
    // detector levels are synchronised, so give them a few cycles
    sequence s_short_held;
        (regulator_enabled && regulator_short) [*4];
    endsequence
    sequence s_slow_held;
        (regulator_enabled && !full_speed_ok) [*4];
    endsequence
    property p_rev_word;
        s_rev_read |=> reg_rdata == {28'h0, REVISION_ID};
    endproperty
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_settle_hold;
        $rose(exec_enable) && regulator_enabled |-> low_cnt_r >= SETTLE_CYCLES;
    endproperty
    property p_track_enter;
        s_slow_held |-> tracking_mode;
    endproperty
    property p_no_full_speed;
        tracking_mode [*2] |-> !full_speed_allowed;
    endproperty
    property p_lv_only_on;
        low_voltage_flag |-> regulator_enabled;
    endproperty
    property p_bo_from_short;
        s_short_held |-> ##[0:2] brownout_reset;
    endproperty
    property p_bo_only_on;
        brownout_reset |-> regulator_enabled && !exec_enable;
    endproperty
    a_rev_word: assert property (p_rev_word)
        else $error("revision word read wrong");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read");
    a_settle_hold: assert property (p_settle_hold)
        else $error("code released before settle time");
    a_track_enter: assert property (p_track_enter)
        else $error("tracking not entered on low supply");
    a_no_full_speed: assert property (p_no_full_speed)
        else $error("full speed allowed while tracking");
    a_lv_only_on: assert property (p_lv_only_on)
        else $error("low voltage flag with regulator off");
    a_bo_from_short: assert property (p_bo_from_short)
        else $error("no brownout on starved regulator");
    a_bo_only_on: assert property (p_bo_only_on)
        else $error("brownout with regulator off or code running");
endmodule : regulator_seq_checker
bind core_regulator_reset_sequencer regulator_seq_checker #(
    .REVISION_ID(REVISION_ID)
) u_regulator_seq_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .regulator_short(regulator_short),
    .full_speed_ok(full_speed_ok), .exec_enable(exec_enable),
    .brownout_reset(brownout_reset), .tracking_mode(tracking_mode),
    .full_speed_allowed(full_speed_allowed), .low_voltage_flag(low_voltage_flag),
    .regulator_enabled(regulator_enabled)
);
`default_nettype wire

// file: bench/supply_detector_model.sv
`timescale 1ns/1ps
`default_nettype none
module supply_detector_model (
    input  wire logic       core_clk,
    input  wire logic [1:0] level,           // 0 none, 1 starved, 2 tracking, 3 full
    input  wire logic       short_cmd,       // regulator input too weak
    input  wire logic [2:0] lag,             // prompt or slow stable report
    output var  logic       supply_stable,
    output var  logic       full_speed_ok,
    output var  logic       tracking_ok,
    output var  logic       regulator_short
);
    logic [2:0] wait_r = 3'h0; // cycles left before stable is reported
    initial {supply_stable, full_speed_ok, tracking_ok, regulator_short} = 4'h0;
    // detectors change just after an edge, as real comparators seen through a flop
    always @(posedge core_clk) begin
        full_speed_ok   <= (level == 2'h3);
        tracking_ok     <= (level >= 2'h2);
        regulator_short <= short_cmd;
        if (level == 2'h0) begin
            wait_r        <= lag;
            supply_stable <= 1'b0;
        end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
        end else begin
            supply_stable <= 1'b1;
        end
    end
endmodule : supply_detector_model
`default_nettype wire

// file: bench/test_core_regulator_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_core_regulator_reset_sequencer;
    import regulator_seq_pkg::*;
    localparam int unsigned PU_CYC = 20;   // shortened power-up timer
    localparam logic [3:0]  REV_ID = 4'h1; // arbitrary value
    logic              core_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              regulator_strap = 1'b1;
    logic              wake_event = 1'b0;
    logic              short_cmd = 1'b0;
    logic [1:0]        level = 2'h0;
    logic [2:0]        lag = 3'h0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic supply_stable, full_speed_ok, tracking_ok, regulator_short;
    logic exec_enable, brownout_reset, tracking_mode;
    logic full_speed_allowed, low_voltage_flag, regulator_enabled;
    logic [31:0]       seed = 32'h3c; // xorshift state
    int                fail_count = 0;
    int                total_checks = 0;
    int                cycles = 0;
    int                n;
    core_regulator_reset_sequencer #(
        .REVISION_ID(REV_ID), .POWERUP_CYCLES(PU_CYC)
    ) u_core_regulator_reset_sequencer (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .regulator_strap(regulator_strap), .supply_stable(supply_stable),
        .full_speed_ok(full_speed_ok), .tracking_ok(tracking_ok),
        .regulator_short(regulator_short), .wake_event(wake_event),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_enable(exec_enable),
        .brownout_reset(brownout_reset), .tracking_mode(tracking_mode),
        .full_speed_allowed(full_speed_allowed),
        .low_voltage_flag(low_voltage_flag), .regulator_enabled(regulator_enabled)
    );
    supply_detector_model u_supply_detector_model (
        .core_clk(core_clk), .level(level), .short_cmd(short_cmd), .lag(lag),
        .supply_stable(supply_stable), .full_speed_ok(full_speed_ok),
        .tracking_ok(tracking_ok), .regulator_short(regulator_short)
    );
    always #5 core_clk = ~core_clk;
    // hang guard, well above the longest expected run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("mismatch at %0t: run hung", $time);
            complete_run();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata === exp, what);
    endtask : reg_read
    // edges until code runs; outputs are looked at once the edge has landed
    task automatic wait_exec(output int cnt);
        cnt = 0;
        while (exec_enable !== 1'b1 && cnt < 9000) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask : wait_exec
    task automatic do_reset(input logic strap);
        @(posedge core_clk);
        sys_rst         <= 1'b1;
        level           <= 2'h0;
        short_cmd       <= 1'b0;
        regulator_strap <= strap;
        lag             <= 3'(rnd());
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask : do_reset
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        logic [3:0] a;
        do_reset(1'b1);
        reg_read(OFS_SILICON_REVISION, {28'h0, REV_ID}, "revision");
        reg_write(OFS_SILICON_REVISION, 32'hffffffff);
        reg_read(OFS_SILICON_REVISION, {28'h0, REV_ID}, "revision after write");
        reg_read(OFS_RESET_CAUSE, 32'h1, "cause after reset");
        // random probes of holes in the map read as zero
        repeat (6) begin
            a = 4'(rnd());
            if (a[1:0] != 2'h0) reg_read(a, 32'h0, "unmapped read");
        end
        reg_write(OFS_RESET_CAUSE, 32'h0);
        level <= 2'h3;
        wait_exec(n);
        check(n >= SETTLE_CYCLES && n <= SETTLE_CYCLES + 20, "settle time");
        check(regulator_enabled === 1'b1, "strap high, regulator on");
        $display("power-up with regulator done");
        level <= 2'h2;
        repeat (8) @(posedge core_clk);
        check(tracking_mode & exec_enable & low_voltage_flag, "tracking entry");
        reg_read(OFS_STATUS, 32'h0f, "status low supply");
        level <= 2'h3;
        repeat (8) @(posedge core_clk);
        reg_write(OFS_STATUS, 32'h1);
        reg_read(OFS_STATUS, 32'h1c, "status flag cleared");
        reg_write(OFS_CONTROL, 32'h0);
        level <= 2'h2;
        repeat (8) @(posedge core_clk);
        reg_read(OFS_STATUS, 32'h0e, "detection disabled");
        reg_write(OFS_CONTROL, 32'h1);
        level <= 2'h3;
        $display("low-voltage tracking done");
        reg_write(OFS_CONTROL, 32'h3);
        @(posedge core_clk);
        #1;
        check(exec_enable === 1'b0, "sleep stops code");
        reg_read(OFS_CONTROL, 32'h1, "sleep bit reads zero");
        repeat (rnd() % 50) @(posedge core_clk);
        wake_event <= 1'b1;
        wait_exec(n);
        wake_event <= 1'b0;
        check(n >= SETTLE_CYCLES && n <= SETTLE_CYCLES + 12, "wake settle");
        $display("sleep and wake done");
        // brownout by starved regulator, then by supply under tracking minimum
        for (int k = 0; k < 2; k++) begin
            reg_write(OFS_RESET_CAUSE, 32'h0);
            if (k == 0) short_cmd <= 1'b1;
            else level <= 2'h1;
            repeat (8) @(posedge core_clk);
            #1;
            check(brownout_reset === 1'b1 && exec_enable === 1'b0, "brownout");
            reg_read(OFS_RESET_CAUSE, 32'h2, "brownout cause");
            short_cmd <= 1'b0;
            level     <= 2'h3;
            wait_exec(n);
            check(n >= SETTLE_CYCLES && n <= SETTLE_CYCLES + 16, "settle after brownout");
        end
        $display("brownout done");
        do_reset(1'b0);
        level <= 2'h3;
        wait_exec(n);
        check(n >= PU_CYC && n <= PU_CYC + 20, "power-up timer");
        check(regulator_enabled === 1'b0, "strap low, regulator off");
        level     <= 2'h1;
        short_cmd <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        check(brownout_reset === 1'b0 && low_voltage_flag === 1'b0, "off: no detect");
        reg_read(OFS_STATUS, 32'h18, "status regulator off");
        $display("regulator off done");
        complete_run();
    end
endmodule : test_core_regulator_reset_sequencer
`default_nettype wire
